//--- dv/ofd_fetch_model.sv
// Fetch unit model: presents one operand per call, just after a clock edge.
// Assumes send is called right after a rising edge of mclk; idle returns at
// the falling edge so the caller can read settled results.
`timescale 1ns/100ps
module ofd_fetch_model
(
   // Clock.
   input  wire logic        mclk,
   // Request to the decoder.
   output logic             opValid  = 1'b0,
   output logic [3:0]       opKind   = 4'h0,
   output logic [7:0]       opByte0  = 8'h00,
   output logic [7:0]       opByte1  = 8'h00,
   output logic [7:0]       opByte2  = 8'h00,
   output logic [15:0]      nextPc   = 16'h0000,
   // Operands of a two-operand add.
   output logic [7:0]       dstValue = 8'h00,
   output logic [7:0]       srcValue = 8'h00
);
   task send(input [3:0] k, input [23:0] b, input [15:0] pc);
      {opValid, opKind, opByte0, opByte1, opByte2, nextPc} <= {1'b1, k, b, pc};
      {dstValue, srcValue} <= b[23:8];
      @(posedge mclk);
   endtask
   // Released byte lines flip so stale values cannot pass for live ones.
   task idle;
      opValid <= 0;
      {opByte0, opByte1, opByte2} <= ~{opByte0, opByte1, opByte2};
      @(negedge mclk);
   endtask
endmodule // ofd_fetch_model

//--- dv/ofd_operand_checker.sv
// Result checks for the operand decoder.
// Assumes opValid stays low while rst_n is low.
`timescale 1ns/100ps
module ofd_operand_checker
(
   // Clock and reset.
   input wire logic        mclk,
   input wire logic        rst_n,
   // Request from fetch.
   input wire logic        opValid,
   input wire logic [3:0]  opKind,
   input wire logic [7:0]  opByte0,
   input wire logic [7:0]  opByte1,
   input wire logic [7:0]  opByte2,
   input wire logic [15:0] nextPc,
   input wire logic [7:0]  dstValue,
   input wire logic [7:0]  srcValue,
   // Decoded result.
   input wire logic        resValid,
   input wire logic        resError,
   input wire logic [2:0]  bitIndex,
   input wire logic        polarity,
   input wire logic [15:0] targetAddr,
   input wire logic [11:0] fileAddr,
   input wire logic        workSlotSel,
   input wire logic [3:0]  workSlot,
   input wire logic [7:0]  literalByte,
   input wire logic [7:0]  trapVector,
   input wire logic [7:0]  sumByte,
   input wire logic        sumCarry
);
   // Request as taken at the last edge; kind f marks that none was taken.
   logic [3:0]  k;
   logic [7:0]  b, c, d;
   logic        v;
   logic [8:0]  sum9;
   logic [15:0] pc;
   always @(posedge mclk)
   begin
      v    <= opValid && rst_n;
      k    <= (opValid && rst_n) ? opKind : 4'hf;
      b    <= opByte0;
      c    <= opByte1;
      d    <= opByte2;
      pc   <= nextPc;
      sum9 <= {1'b0, dstValue} + {1'b0, srcValue};
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   property p_valid; resValid == v; endproperty
   a_valid: assert property (p_valid) else $error("valid");
   property p_bit; k == 4'h0 |-> bitIndex == b[2:0]; endproperty
   a_bit: assert property (p_bit) else $error("bit");
   property p_dir; k == 4'h1 |-> targetAddr == {b, c}; endproperty
   a_dir: assert property (p_dir) else $error("dir");
   property p_ext; k == 4'h2 |-> fileAddr == {b[3:0], c}; endproperty
   a_ext: assert property (p_ext) else $error("ext");
   property p_imm; k == 4'h3 |-> literalByte == b; endproperty
   a_imm: assert property (p_imm) else $error("imm");
   property p_fp;
      k == 4'h4 && b[7:4] != 4'he |-> fileAddr == {4'h0, b[7:1], 1'b0} && resError == b[0];
   endproperty
   a_fp: assert property (p_fp) else $error("fpair");
   property p_wp; k == 4'h5 |-> !workSlot[0] && resError == b[0]; endproperty
   a_wp: assert property (p_wp) else $error("wpair");
   property p_rel; k == 4'h6 |-> targetAddr == pc + {{8{b[7]}}, b}; endproperty
   a_rel: assert property (p_rel) else $error("rel");
   property p_idx; k == 4'h7 |-> targetAddr == {c, d} + {{8{b[7]}}, b}; endproperty
   a_idx: assert property (p_idx) else $error("index");
   property p_pol; k == 4'h8 |-> polarity == b[0]; endproperty
   a_pol: assert property (p_pol) else $error("polarity");
   property p_trap; k == 4'h9 |-> trapVector == b; endproperty
   a_trap: assert property (p_trap) else $error("trap");
   property p_add; k == 4'ha |-> {sumCarry, sumByte} == sum9; endproperty
   a_add: assert property (p_add) else $error("add");
   property p_reg;
      k == 4'hb |-> workSlotSel == (b[7:4] == 4'he)
                    && (workSlotSel ? workSlot == b[3:0] : fileAddr == {4'h0, b});
   endproperty
   a_reg: assert property (p_reg) else $error("reg");
   cover property (k == 4'h6);
   cover property (k == 4'h5);
   cover property (k == 4'ha);
endmodule // ofd_operand_checker
bind ofd_operand_decoder ofd_operand_checker u_ofd_operand_checker(.*);

//--- dv/tb_operand_field_decoder.sv
// Self-checking bench for the operand decoder.
// Assumes results other than resValid, resError and workSlotSel hold until a request that writes them.
`timescale 1ns/100ps
module tb_operand_field_decoder;
   logic mclk = 0, rst_n = 0;
   int err_count = 0, checks_done = 0;
   wire opValid, resValid, resError, polarity, workSlotSel, sumCarry;
   wire [3:0] opKind, workSlot;
   wire [7:0] opByte0, opByte1, opByte2, dstValue, srcValue, literalByte, trapVector, sumByte;
   wire [2:0] bitIndex;
   wire [15:0] nextPc, targetAddr;
   wire [11:0] fileAddr;
   always #2.5 mclk = ~mclk;
   ofd_fetch_model u_ofd_fetch_model(.*);
   ofd_operand_decoder u_ofd_operand_decoder(.*);
   // Results are read mid-cycle; a new request starts back on a rising edge.
   task s(input [3:0] k, input [23:0] b, input [15:0] pc = 0);
      if (!mclk) @(posedge mclk);
      u_ofd_fetch_model.send(k, b, pc);
   endtask
   task gap;
      u_ofd_fetch_model.idle;
      chk("resValid", resValid, 1);
   endtask
   task chk(string n, logic [15:0] v, e);
      checks_done++;
      if (v !== e)
      begin
         err_count++;
         $display("wrong value %s expected %h seen %h", n, e, v);
      end
   endtask
   task summarize;
      $display("mismatches %0d checks %0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task t_fields;
      s(4'h0, 24'h070000);
      s(4'h8, 24'h010000);
      s(4'h1, 24'hffff00);
      s(4'h2, 24'h0fff00);
      s(4'h3, 24'hff0000);
      s(4'h9, 24'ha50000);
      gap;
      chk("bitIndex", bitIndex, 7);
      chk("polarity", polarity, 1);
      chk("targetAddr", targetAddr, 16'hffff);
      chk("fileAddr", fileAddr, 12'hfff);
      chk("literalByte", literalByte, 8'hff);
      chk("trapVector", trapVector, 8'ha5);
   endtask
   task t_pairs;
      s(4'h4, 24'h030000);
      gap;
      chk("oddPair", {resError, fileAddr}, 16'h1002);
      s(4'h5, 24'h0e0000);
      gap;
      chk("slotPair", {resError, workSlot}, 5'h0e);
      s(4'h4, 24'he50000);
      gap;
      chk("escPair", {resError, workSlotSel, workSlot}, 6'h34);
      s(4'hc, 24'h000000);
      gap;
      chk("badKind", resError, 1);
   endtask
   task t_reset;
      @(posedge mclk);
      rst_n <= 0;
      repeat (2) @(posedge mclk);
      rst_n <= 1;
      @(negedge mclk);
      chk("rstTarget", targetAddr, 0);
      chk("rstFile", {resError, workSlotSel, fileAddr}, 0);
      chk("rstFields", {bitIndex, literalByte}, 0);
      chk("rstSum", {resValid, sumCarry, sumByte}, 0);
   endtask
   task t_rel;
      s(4'h6, 24'hff0000, 16'h0100);
      gap;
      chk("relTarget", targetAddr, 16'h00ff);
      s(4'h6, 24'h7f0000, 16'hffff);
      gap;
      chk("relWrap", targetAddr, 16'h007e);
      s(4'h7, 24'h801234);
      gap;
      chk("indexed", targetAddr, 16'h11b4);
   endtask
   task t_add;
      s(4'ha, 24'hf02000);
      gap;
      chk("sum", {sumCarry, sumByte}, 9'h110);
   endtask
   task t_reg;
      s(4'hb, 24'he80000);
      gap;
      chk("escaped", {workSlotSel, workSlot}, 5'h18);
      s(4'hb, 24'h430000);
      gap;
      chk("plainReg", workSlotSel, 0);
      chk("plainFile", fileAddr, 12'h043);
   endtask
   initial
   begin
      repeat (3) @(posedge mclk);
      rst_n <= 1;
      t_fields;
      t_pairs;
      t_reset;
      t_rel;
      t_add;
      t_reg;
      summarize;
   end
endmodule // tb_operand_field_decoder

//--- hw/ofd_operand_decoder.v
// Operand field decoder: turns fetched operand fields into indices and addresses.
// Assumes the fetch unit gives a one-cycle opValid with kind, bytes and next-PC
// on mclk; results are registered and appear one cycle later with resValid.
`timescale 1ns/100ps
`include "ofd_operand_map.vh"
module ofd_operand_decoder
#(
   parameter ADDR_W = `OFD_ADDR_W,
   parameter FILE_W = `OFD_FILE_W
)
(
   // Clock and reset.
   input  wire               mclk,
   input  wire               rst_n,
   // Request from fetch.
   input  wire               opValid,
   input  wire [3:0]         opKind,
   input  wire [7:0]         opByte0,
   input  wire [7:0]         opByte1,
   input  wire [7:0]         opByte2,
   input  wire [ADDR_W-1:0]  nextPc,
   input  wire [7:0]         dstValue,
   input  wire [7:0]         srcValue,
   // Decoded result.
   output wire               resValid,
   output wire               resError,
   output wire [2:0]         bitIndex,
   output wire               polarity,
   output wire [ADDR_W-1:0]  targetAddr,
   output wire [FILE_W-1:0]  fileAddr,
   output wire               workSlotSel,
   output wire [3:0]         workSlot,
   output wire [7:0]         literalByte,
   output wire [7:0]         trapVector,
   output wire [7:0]         sumByte,
   output wire               sumCarry
);

   // ************************************************************
   // Field helpers
   // ************************************************************

   // True when an 8-bit register field holds the escape form.
   function isEscaped;
      input [7:0] b;
      begin
         isEscaped = (b[7:4] == `OFD_ESC_NIBBLE);
      end
   endfunction

   // Work slot of a couple: the odd member is dropped so that the pair
   // always starts on an even slot, whatever the low bit held.
   function [3:0] evenSlot;
      input [7:0] b;
      begin
         evenSlot = {b[3:1], 1'h0};
      end
   endfunction

   // File couple address, widened to the file width with its low bit even.
   function [FILE_W-1:0] evenFile;
      input [7:0] b;
      begin
         evenFile = {{(FILE_W-8){1'h0}}, b[7:1], 1'h0};
      end
   endfunction

   // ************************************************************
   // Combinational arithmetic
   // ************************************************************

   wire [ADDR_W-1:0] relTarget;
   wire [ADDR_W-1:0] idxTarget;
   wire [8:0]        addSum;

   ofd_signed_adder #(.BASE_W(ADDR_W)) uRel
   (
      .base   (nextPc),
      .offset (opByte0),
      .sum    (relTarget)
   );

   ofd_signed_adder #(.BASE_W(ADDR_W)) uIdx
   (
      .base   ({opByte1, opByte2}),
      .offset (opByte0),
      .sum    (idxTarget)
   );

   assign addSum = {1'h0, dstValue} + {1'h0, srcValue};

   // ************************************************************
   // Result state
   // ************************************************************

   reg               resValid_q;
   reg               resValid_d;
   reg               resError_q;
   reg               resError_d;
   reg [2:0]         bitIndex_q;
   reg [2:0]         bitIndex_d;
   reg               polarity_q;
   reg               polarity_d;
   reg [ADDR_W-1:0]  targetAddr_q;
   reg [ADDR_W-1:0]  targetAddr_d;
   reg [FILE_W-1:0]  fileAddr_q;
   reg [FILE_W-1:0]  fileAddr_d;
   reg               workSlotSel_q;
   reg               workSlotSel_d;
   reg [3:0]         workSlot_q;
   reg [3:0]         workSlot_d;
   reg [7:0]         literalByte_q;
   reg [7:0]         literalByte_d;
   reg [7:0]         trapVector_q;
   reg [7:0]         trapVector_d;
   reg [7:0]         sumByte_q;
   reg [7:0]         sumByte_d;
   reg               sumCarry_q;
   reg               sumCarry_d;

   // ************************************************************
   // Next-value decode
   // ************************************************************

   // Only resValid, resError, workSlotSel and the fields of the requested kind move; the others hold, so the
   // core may still read an earlier result after operands of other kinds.
   always @*
   begin
      resValid_d    = opValid;
      resError_d    = resError_q;
      bitIndex_d    = bitIndex_q;
      polarity_d    = polarity_q;
      targetAddr_d  = targetAddr_q;
      fileAddr_d    = fileAddr_q;
      workSlotSel_d = workSlotSel_q;
      workSlot_d    = workSlot_q;
      literalByte_d = literalByte_q;
      trapVector_d  = trapVector_q;
      sumByte_d     = sumByte_q;
      sumCarry_d    = sumCarry_q;
      if (opValid)
      begin
         // Error and slot select describe the latest request only.
         resError_d    = 1'h0;
         workSlotSel_d = 1'h0;
         case (opKind)
            `OFD_KIND_BIT:
               bitIndex_d = opByte0[2:0];
            `OFD_KIND_POL:
               polarity_d = opByte0[0];
            `OFD_KIND_DIRECT:
               targetAddr_d = {opByte0, opByte1};
            `OFD_KIND_EXT:
               fileAddr_d = {opByte0[3:0], opByte1};
            `OFD_KIND_IMM:
               literalByte_d = opByte0;
            `OFD_KIND_TRAP:
               trapVector_d = opByte0;
            `OFD_KIND_REG:
            begin
               if (isEscaped(opByte0))
               begin
                  workSlotSel_d = 1'h1;
                  workSlot_d    = opByte0[3:0];
               end
               else
               begin
                  fileAddr_d = {{(FILE_W-8){1'h0}}, opByte0};
               end
            end
            `OFD_KIND_FPAIR:
            begin
               // An odd couple is flagged but still decoded with its low bit even.
               resError_d = opByte0[0];
               if (isEscaped(opByte0))
               begin
                  workSlotSel_d = 1'h1;
                  workSlot_d    = evenSlot(opByte0);
               end
               else
               begin
                  fileAddr_d = evenFile(opByte0);
               end
            end
            `OFD_KIND_WPAIR:
            begin
               workSlotSel_d = 1'h1;
               workSlot_d    = evenSlot(opByte0);
               resError_d    = opByte0[0];
            end
            `OFD_KIND_REL:
               targetAddr_d = relTarget;
            `OFD_KIND_INDEX:
               targetAddr_d = idxTarget;
            `OFD_KIND_ADD:
            begin
               sumByte_d  = addSum[7:0];
               sumCarry_d = addSum[8];
            end
            default:
               resError_d = 1'h1;
         endcase
      end
   end

   // ************************************************************
   // Result registers
   // ************************************************************

   always @(posedge mclk)
   begin
      if (!rst_n)
      begin
         resValid_q    <= 1'h0;
         resError_q    <= 1'h0;
         bitIndex_q    <= 3'h0;
         polarity_q    <= 1'h0;
         targetAddr_q  <= {ADDR_W{1'h0}};
         fileAddr_q    <= {FILE_W{1'h0}};
         workSlotSel_q <= 1'h0;
         workSlot_q    <= 4'h0;
         literalByte_q <= 8'h00;
         trapVector_q  <= 8'h00;
         sumByte_q     <= 8'h00;
         sumCarry_q    <= 1'h0;
      end
      else
      begin
         resValid_q    <= resValid_d;
         resError_q    <= resError_d;
         bitIndex_q    <= bitIndex_d;
         polarity_q    <= polarity_d;
         targetAddr_q  <= targetAddr_d;
         fileAddr_q    <= fileAddr_d;
         workSlotSel_q <= workSlotSel_d;
         workSlot_q    <= workSlot_d;
         literalByte_q <= literalByte_d;
         trapVector_q  <= trapVector_d;
         sumByte_q     <= sumByte_d;
         sumCarry_q    <= sumCarry_d;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************

   assign resValid    = resValid_q;
   assign resError    = resError_q;
   assign bitIndex    = bitIndex_q;
   assign polarity    = polarity_q;
   assign targetAddr  = targetAddr_q;
   assign fileAddr    = fileAddr_q;
   assign workSlotSel = workSlotSel_q;
   assign workSlot    = workSlot_q;
   assign literalByte = literalByte_q;
   assign trapVector  = trapVector_q;
   assign sumByte     = sumByte_q;
   assign sumCarry    = sumCarry_q;

endmodule // ofd_operand_decoder

//--- hw/ofd_operand_map.vh
// Constants for the operand field decoder: field widths, escape code, operand kinds.
// Assumes the fetch unit presents operand bytes already aligned to their fields.
`ifndef OFD_OPERAND_MAP_VH
`define OFD_OPERAND_MAP_VH
`define OFD_BIT_W        3
`define OFD_ADDR_W       16
`define OFD_FILE_W       12
`define OFD_BYTE_W       8
`define OFD_SLOT_W       4
`define OFD_ESC_NIBBLE   4'he
`define OFD_KIND_W       4
`define OFD_KIND_BIT     4'h0
`define OFD_KIND_DIRECT  4'h1
`define OFD_KIND_EXT     4'h2
`define OFD_KIND_IMM     4'h3
`define OFD_KIND_FPAIR   4'h4
`define OFD_KIND_WPAIR   4'h5
`define OFD_KIND_REL     4'h6
`define OFD_KIND_INDEX   4'h7
`define OFD_KIND_POL     4'h8
`define OFD_KIND_TRAP    4'h9
`define OFD_KIND_ADD     4'ha
`define OFD_KIND_REG     4'hb
`endif

//--- hw/ofd_signed_adder.v
// Adds a sign-extended 8-bit offset to a 16-bit base, wrapping modulo 2^16.
// Assumes purely combinational use by the decoder on the same clock.
`timescale 1ns/100ps
module ofd_signed_adder
#(
   parameter BASE_W = 16
)
(
   // Operands.
   base,
   offset,
   // Result.
   sum
);
   input  wire [BASE_W-1:0] base;
   input  wire [7:0]        offset;
   output wire [BASE_W-1:0] sum;

   // Sign extension keeps -128..+127 exact for any base width of eight or more.
   assign sum = base + {{(BASE_W-8){offset[7]}}, offset};
endmodule // ofd_signed_adder
